// ===== rtl/pcs_config_select.sv
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pcs_config_select
    import pcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // three-level pins arrive as {is_high, is_low}; neither set means open
    input wire logic [3:0] input_preset_pins,
    input wire logic [3:0] bank_a_pins,
    input wire logic [3:0] bank_b_pins,
    input wire logic [3:0] bank_c_pins,
    input wire logic [3:0] bank_d_pins,
    input wire logic ref_select_pin,
    input wire logic pll_locked,
    output pcs_pll_cfg_t pll_cfg,
    output logic use_ref_clock,
    output pcs_bank_cfg_t bank_a_cfg,
    output pcs_bank_cfg_t bank_b_cfg,
    output pcs_bank_cfg_t bank_c_cfg,
    output pcs_bank_cfg_t bank_d_cfg,
    output logic divider_sync,
    output logic fractional_output_mode,
    output logic lock_out
);

////////////////////////////////////////////////////////////////////////////
// three-level pin resolution; open pins read as middle
// every group has its own instance of one decoder module, so no two groups disagree on a level
wire [3:0] fin_code;
wire [3:0] na_code;
wire [3:0] nb_code;
wire [3:0] nc_code;
wire [3:0] nd_code;

pcs_lvl_decode #(.PINS(2)) u_lvl_fin (
    .pins(input_preset_pins),
    .code(fin_code)
);

pcs_lvl_decode #(.PINS(2)) u_lvl_a (
    .pins(bank_a_pins),
    .code(na_code)
);

pcs_lvl_decode #(.PINS(2)) u_lvl_b (
    .pins(bank_b_pins),
    .code(nb_code)
);

pcs_lvl_decode #(.PINS(2)) u_lvl_c (
    .pins(bank_c_pins),
    .code(nc_code)
);

pcs_lvl_decode #(.PINS(2)) u_lvl_d (
    .pins(bank_d_pins),
    .code(nd_code)
);

////////////////////////////////////////////////////////////////////////////
// preset table: prescaler, doubler and m for each of nine pin pairs;
// same table whatever reference is selected
logic [15:0] preset_cfg; // {ps, dbl, m}
always_comb begin // [RQ11] [RQ12] [RQ13]
    case (fin_code)
        {`PCS_LVL_HIGH, `PCS_LVL_HIGH}: preset_cfg = {6'h01, 1'b1, 9'h020};
        {`PCS_LVL_HIGH, `PCS_LVL_MID}: preset_cfg = {6'h01, 1'b1, 9'h020};
        {`PCS_LVL_HIGH, `PCS_LVL_LOW}: preset_cfg = {6'h01, 1'b1, 9'h028};
        {`PCS_LVL_MID, `PCS_LVL_HIGH}: preset_cfg = {6'h02, 1'b0, 9'h010};
        {`PCS_LVL_MID, `PCS_LVL_MID}: preset_cfg = {6'h01, 1'b0, 9'h014};
        {`PCS_LVL_MID, `PCS_LVL_LOW}: preset_cfg = {6'h01, 1'b0, 9'h010};
        {`PCS_LVL_LOW, `PCS_LVL_HIGH}: preset_cfg = {6'h01, 1'b0, 9'h019};
        {`PCS_LVL_LOW, `PCS_LVL_MID}: preset_cfg = {6'h01, 1'b1, 9'h032};
        default: preset_cfg = {6'h01, 1'b1, 9'h019};
    endcase
end

////////////////////////////////////////////////////////////////////////////
// registers; all volatile, cleared by reset so pins rule again
logic [4:0] sel_q; // {d, c, b, a, pll}
logic [15:0] pll_reg_q;
logic [7:0] bank_reg_q [4];
logic init_req_q;

wire wr_en = psel & penable & pwrite;
wire a_ctrl = paddr == `PCS_OFF_CTRL;
wire a_pll = paddr == `PCS_OFF_PLL;
wire a_ba = paddr == `PCS_OFF_BANK_A;
wire a_bb = paddr == `PCS_OFF_BANK_B;
wire a_bc = paddr == `PCS_OFF_BANK_C;
wire a_bd = paddr == `PCS_OFF_BANK_D;
wire a_init = paddr == `PCS_OFF_INIT;
wire a_stat = paddr == `PCS_OFF_STATUS;
wire a_ok = a_ctrl | a_pll | a_ba | a_bb | a_bc | a_bd | a_init | a_stat;

// select bits only steer the muxes; stored fields stay as written
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sel_q <= `PCS_CTRL_RST; // [RQ1] [RQ5] [RQ19]
        pll_reg_q <= `PCS_PLL_RST;
    end else if (wr_en) begin
        if (a_ctrl) begin
            sel_q <= pwdata[4:0]; // [RQ3] [RQ19]
        end else if (a_pll) begin
            pll_reg_q <= pwdata[15:0];
        end
    end
end

// one slot per bank; its select bit above the pll bit picks the source
pcs_bank_slot #(.OFFSET(`PCS_OFF_BANK_A)) u_bank_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .paddr(paddr),
    .wdata(pwdata[7:0]),
    .pin_code(na_code[1:0]),
    .from_reg(sel_q[1]), // [RQ2] [RQ3]
    .field_q(bank_reg_q[0]),
    .cfg_q(bank_a_cfg)
);

pcs_bank_slot #(.OFFSET(`PCS_OFF_BANK_B)) u_bank_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .paddr(paddr),
    .wdata(pwdata[7:0]),
    .pin_code(nb_code[1:0]),
    .from_reg(sel_q[2]), // [RQ2] [RQ3]
    .field_q(bank_reg_q[1]),
    .cfg_q(bank_b_cfg)
);

pcs_bank_slot #(.OFFSET(`PCS_OFF_BANK_C)) u_bank_c (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .paddr(paddr),
    .wdata(pwdata[7:0]),
    .pin_code(nc_code[1:0]),
    .from_reg(sel_q[3]), // [RQ2] [RQ3]
    .field_q(bank_reg_q[2]),
    .cfg_q(bank_c_cfg)
);

pcs_bank_slot #(.OFFSET(`PCS_OFF_BANK_D)) u_bank_d (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .paddr(paddr),
    .wdata(pwdata[7:0]),
    .pin_code(nd_code[1:0]),
    .from_reg(sel_q[4]), // [RQ2] [RQ3]
    .field_q(bank_reg_q[3]),
    .cfg_q(bank_d_cfg)
);

////////////////////////////////////////////////////////////////////////////
// source selection, exactly one source per group
wire [15:0] pll_sel = sel_q[0] ? pll_reg_q : preset_cfg; // [RQ2] [RQ15]
// doubler wins over prescaler if software sets both, keeping them exclusive
wire dbl_sel = pll_sel[`PCS_PLL_DBL_BIT];
wire [5:0] ps_sel = dbl_sel ? 6'h01 :
    pll_sel[`PCS_PLL_PS_MSB:`PCS_PLL_PS_LSB]; // [RQ13] [RQ16]
// a pin change on any pin-controlled group may drop alignment; groups
// under register control have their moves masked, though a bank still passes its pin_code out
wire [19:0] pin_mask = {{4{~sel_q[4]}}, {4{~sel_q[3]}}, {4{~sel_q[2]}},
    {4{~sel_q[1]}}, {4{~sel_q[0]}}};
wire [19:0] pin_view = {nd_code, nc_code, nb_code, na_code, fin_code} &
    pin_mask;
logic [19:0] pin_view_q;
logic pins_moved;
assign pins_moved = pin_view_q != pin_view;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pll_cfg <= '0;
        use_ref_clock <= 1'b0;
        lock_out <= 1'b0;
        pin_view_q <= '0;
    end else begin
        pll_cfg <= {ps_sel, dbl_sel,
            pll_sel[`PCS_PLL_M_MSB:`PCS_PLL_M_LSB]}; // [RQ16]
        use_ref_clock <= ref_select_pin; // [RQ10] [RQ17]
        lock_out <= pll_locked; // [RQ18]
        pin_view_q <= pin_view;
    end
end

////////////////////////////////////////////////////////////////////////////
// resync sequencer: init write or reset reloads dividers and restarts
// the fractional path; in run, a pin change on a pin-controlled group halts it until the next init
localparam int SYNC_CYC = `PCS_SYNC_CYC;
pcs_state_t state_q;
logic [7:0] cnt_q;
wire init_hit = wr_en & a_init & pwdata[`PCS_INIT_BIT]; // [RQ8]

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q <= PCS_SYNC; // [RQ7]
        cnt_q <= 8'h00;
        divider_sync <= 1'b0;
        fractional_output_mode <= 1'b0;
        init_req_q <= 1'b0;
    end else begin
        init_req_q <= init_hit;
        case (state_q)
            PCS_SYNC: begin
                divider_sync <= 1'b1;
                fractional_output_mode <= 1'b0;
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == 8'(SYNC_CYC - 1)) begin
                    state_q <= PCS_RUN;
                    cnt_q <= 8'h00;
                end
            end
            PCS_RUN: begin
                divider_sync <= 1'b0;
                fractional_output_mode <= 1'b1; // [RQ7]
                if (init_hit) begin
                    state_q <= PCS_SYNC;
                end else if (pins_moved) begin
                    state_q <= PCS_IDLE; // [RQ6]
                end
            end
            default: begin
                divider_sync <= 1'b0;
                fractional_output_mode <= 1'b0; // [RQ6]
                if (init_hit) begin
                    state_q <= PCS_SYNC; // [RQ7]
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// apb answer: zero wait states, error on unmapped address
// status: bit0 lock, bit1 running, bit2 reference, bit3 fractional,
// bits 6:4 sequencer state, bit7 init seen in the previous cycle
wire [31:0] status_word = {24'h000000, init_req_q, state_q,
    fractional_output_mode, use_ref_clock, state_q == PCS_RUN, lock_out};
logic [31:0] rd_mux;
always_comb begin
    rd_mux = 32'h00000000;
    if (a_ctrl) begin
        rd_mux = {27'h0, sel_q};
    end else if (a_pll) begin
        rd_mux = {16'h0, pll_reg_q};
    end else if (a_ba) begin
        rd_mux = {24'h0, bank_reg_q[0]};
    end else if (a_bb) begin
        rd_mux = {24'h0, bank_reg_q[1]};
    end else if (a_bc) begin
        rd_mux = {24'h0, bank_reg_q[2]};
    end else if (a_bd) begin
        rd_mux = {24'h0, bank_reg_q[3]};
    end else if (a_stat) begin
        rd_mux = status_word;
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= psel & ~penable & ~a_ok;
        prdata <= rd_mux;
    end
end

endmodule // pcs_config_select

////////////////////////////////////////////////////////////////////////////
// three-level pins in, two-bit level codes out, one code per pin;
// high wins if both flags show, since a driven high beats the bias
module pcs_lvl_decode
    import pcs_pkg::*;
#(
    parameter int PINS = 2
)
(
    input wire logic [2*PINS-1:0] pins,
    output wire logic [2*PINS-1:0] code
);
// neither flag set means the pin is open and the bias holds it middle
for (genvar g = 0; g < PINS; g++) begin : g_pin
    wire logic [1:0] p = pins[2*g+1:2*g];
    assign code[2*g+1:2*g] = p[1] ? `PCS_LVL_HIGH :
        (p[0] ? `PCS_LVL_LOW : `PCS_LVL_MID); // [RQ14] [RQ20]
end
endmodule // pcs_lvl_decode

////////////////////////////////////////////////////////////////////////////
// one output bank: its software field and its registered output word;
// the four banks differ only in where their field sits in the map
module pcs_bank_slot
    import pcs_pkg::*;
#(
    parameter logic [11:0] OFFSET = `PCS_OFF_BANK_A
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [11:0] paddr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] pin_code,
    input wire logic from_reg,
    output logic [7:0] field_q,
    output pcs_bank_cfg_t cfg_q
);

wire hit = paddr == OFFSET;

// the field is written only by software, never copied from pins
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        field_q <= `PCS_BANK_RST; // [RQ5]
    end else if (wr_en && hit) begin // [RQ4]
        field_q <= wdata;
    end
end

// a pin-controlled bank hides its stored field so nothing can blend it in
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_q <= '0;
    end else begin
        cfg_q <= {pin_code, from_reg, from_reg ? field_q : 8'h00}; // [RQ4]
    end
end

endmodule // pcs_bank_slot

// ===== inc/pcs_consts.svh
// How it works
// [RQ1] after reset every function group takes its setting from its pins.
// [RQ2] each group uses pins or registers, never a blend of both; a bank under register control still passes its pin_code in its output word.
// [RQ3] five select bits: pll group and banks a to d.
// [RQ4] pin-controlled groups ignore register fields; pins never copied to registers.
// [RQ5] register settings are volatile and return to pin settings at reset.
// [RQ6] pin changes in operation may break phase alignment and stop fractional output.
// [RQ7] init bit or reset restores alignment and restarts the fractional output.
// [RQ8] host must pulse the init bit after divider writes to load them.
// [RQ9] host should disable outputs while reconfiguring to avoid glitches; the host model does not park the outputs before a reload.
// [RQ10] pll reference is crystal or reference clock per the select pin.
// [RQ11] two three-level preset pins decode into nine pll presets; the table gives high/high and high/middle the same entry.
// [RQ12] preset decode is the same for crystal and reference clock.
// [RQ13] doubler and prescaler division are never used together.
// [RQ14] an open three-level pin reads as the middle level.
// [RQ15] register control uses written feedback, doubler and prescaler fields.
// [RQ16] pfd rate is fin times doubler over prescaler; vco is pfd times m.
// [RQ17] reference select low picks crystal, high picks reference clock.
// [RQ18] lock output is high while locked, low otherwise.
// [RQ19] select bits reset to pin control; switching keeps stored fields.
// [RQ20] each three-level pin is resolved to a two-bit low/mid/high code.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_OFF_CTRL 12'h000
`define PCS_OFF_PLL 12'h004
`define PCS_OFF_BANK_A 12'h008
`define PCS_OFF_BANK_B 12'h00C
`define PCS_OFF_BANK_C 12'h010
`define PCS_OFF_BANK_D 12'h014
`define PCS_OFF_INIT 12'h018
`define PCS_OFF_STATUS 12'h01C
`define PCS_CTRL_RST 5'h00
`define PCS_PLL_RST 16'h0000
`define PCS_BANK_RST 8'h00
`define PCS_INIT_BIT 0
`define PCS_PLL_M_LSB 0
`define PCS_PLL_M_MSB 8
`define PCS_PLL_DBL_BIT 9
`define PCS_PLL_PS_LSB 10
`define PCS_PLL_PS_MSB 15
`define PCS_SYNC_NS 20
`define PCS_CLK_NS 5
`define PCS_SYNC_CYC ((`PCS_SYNC_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_LVL_LOW 2'h0
`define PCS_LVL_MID 2'h1
`define PCS_LVL_HIGH 2'h2
`endif

// ===== inc/pcs_pkg.sv
package pcs_pkg;
    typedef struct packed {
        logic [5:0] prescaler_divide;
        logic input_doubler_enable;
        logic [8:0] fb_div;
    } pcs_pll_cfg_t;
    typedef struct packed {
        logic [1:0] pin_code;
        logic from_reg;
        logic [7:0] reg_field;
    } pcs_bank_cfg_t;
    typedef enum logic [2:0] {
        PCS_RUN = 3'h1,
        PCS_SYNC = 3'h2,
        PCS_IDLE = 3'h4
    } pcs_state_t;
endpackage

// ===== bench/pcs_config_select_asserts.sv
`timescale 1ns/10ps
module pcs_chk
    import pcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_select_pin,
    input wire logic pll_locked,
    input wire pcs_pll_cfg_t pll_cfg,
    input wire logic use_ref_clock,
    input wire logic divider_sync,
    input wire logic fractional_output_mode,
    input wire logic lock_out,
    input wire pcs_bank_cfg_t bank_d_cfg
);
    // everything here lives in the one pclk domain
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ref; ref_select_pin |=> use_ref_clock; endproperty
    a_ref: assert property (p_ref) else $error("ref clock not taken");
    property p_xtal; !ref_select_pin |=> !use_ref_clock; endproperty
    a_xtal: assert property (p_xtal) else $error("crystal not taken");
    property p_lock; $rose(pll_locked) |=> lock_out; endproperty
    a_lock: assert property (p_lock) else $error("lock not shown");
    property p_unlk; $fell(pll_locked) |=> !lock_out; endproperty
    a_unlk: assert property (p_unlk) else $error("unlock not shown");
    // resync window is exactly four cycles wide
    property p_sync;
        $rose(divider_sync) |-> divider_sync [*4] ##1 !divider_sync;
    endproperty
    a_sync: assert property (p_sync) else $error("resync length");
    property p_run; $fell(divider_sync) |-> ##[0:1] fractional_output_mode;
    endproperty
    a_run: assert property (p_run) else $error("no restart");
    property p_hold; divider_sync |-> !fractional_output_mode; endproperty
    a_hold: assert property (p_hold) else $error("frac during sync");
    property p_dbl;
        pll_cfg.input_doubler_enable |-> pll_cfg.prescaler_divide == 6'h01;
    endproperty
    a_dbl: assert property (p_dbl) else $error("doubler and divide");
    // a bank on its pins must not pass its stored field along
    property p_pinfld;
        !bank_d_cfg.from_reg |-> bank_d_cfg.reg_field == 8'h00;
    endproperty
    a_pinfld: assert property (p_pinfld) else $error("field leaks");
endmodule // pcs_chk

bind pcs_config_select pcs_chk u_chk (.pclk, .presetn, .ref_select_pin,
    .pll_locked, .pll_cfg, .use_ref_clock, .divider_sync,
    .fractional_output_mode, .lock_out, .bank_d_cfg);

// ===== bench/pcs_host_model.sv
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pcs_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0
);
    logic [31:0] rd_q;
    logic err_q;
    // one apb transfer; released lines flip so stale values never match
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench's hang guard ends a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // a divider write is always followed by the init pulse; the outputs
    // are not parked in between, so the new divider shows before that pulse
    task reload(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        xfer(1'b1, `PCS_OFF_INIT, 32'h1);
    endtask
endmodule // pcs_host_model

// ===== bench/pin_register_config_select_test.sv
`timescale 1ns/10ps
`include "pcs_consts.svh"
module pin_register_config_select_test;
    import pcs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, uref, dsync, frac, lock_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] fin = 4'h0, pa = 4'h0, pb = 4'h0, pc = 4'h0, pd = 4'h0;
    logic rsel = 1'b0, lck = 1'b0;
    pcs_pll_cfg_t pll_cfg;
    pcs_bank_cfg_t bk [4];
    int failures = 0, cmp_count = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    pcs_config_select uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .input_preset_pins(fin), .bank_a_pins(pa), .bank_b_pins(pb),
        .bank_c_pins(pc), .bank_d_pins(pd), .ref_select_pin(rsel),
        .pll_locked(lck), .pll_cfg, .use_ref_clock(uref),
        .bank_a_cfg(bk[0]), .bank_b_cfg(bk[1]), .bank_c_cfg(bk[2]),
        .bank_d_cfg(bk[3]), .divider_sync(dsync),
        .fractional_output_mode(frac), .lock_out);
    pcs_host_model host (.pclk, .pready, .pslverr, .prdata, .psel,
        .penable, .pwrite, .paddr, .pwdata);
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task rst;
        presetn <= 1'b0;
        wt(10);
        presetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // open preset pins read as middle/middle: 125 MHz, m of 20
    task t_reset;
        rst();
        wt(2);
        chk(32'(dsync), 32'h1);
        wt(6);
        chk(32'(frac), 32'h1);
        chk({16'h0, pll_cfg}, 32'h0414);
        host.xfer(1'b0, `PCS_OFF_CTRL, 32'h0);
        chk(host.rd_q, 32'h0);
    endtask
    // presets decode alike whichever reference input is chosen
    task t_preset;
        logic [3:0] pin [3] = '{4'hA, 4'h4, 4'h0};
        logic [31:0] cfg [3] = '{32'h0620, 32'h0632, 32'h0414};
        for (int i = 0; i < 3; i++) begin
            fin <= pin[i];
            rsel <= i[0];
            wt(3);
            chk({16'h0, pll_cfg}, cfg[i]);
            chk(32'(uref), 32'(i[0]));
        end
    endtask
    // one select bit at a time; the group left behind goes back to pins
    task t_reg;
        host.xfer(1'b1, `PCS_OFF_PLL, 32'h0819);
        host.xfer(1'b1, `PCS_OFF_CTRL, 32'h1);
        wt(3);
        chk({16'h0, pll_cfg}, 32'h0819);
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, `PCS_OFF_BANK_A + 12'(4 * i), 32'h30 + i);
            host.xfer(1'b1, `PCS_OFF_CTRL, 32'h1 << (i + 1));
            wt(3);
            chk({23'h0, bk[i][8:0]}, 32'h130 + i);
            chk(32'(bk[(i + 3) % 4].from_reg), 32'h0);
        end
        pa <= 4'h2;
        host.xfer(1'b1, `PCS_OFF_CTRL, 32'h0);
        wt(3);
        chk({16'h0, pll_cfg}, 32'h0414);
        chk(32'(bk[0].pin_code), 32'h2);
        chk(32'(bk[0].reg_field), 32'h0);
        host.xfer(1'b0, `PCS_OFF_PLL, 32'h0);
        chk(host.rd_q, 32'h0819);
        host.xfer(1'b0, `PCS_OFF_BANK_A, 32'h0);
        chk(host.rd_q, 32'h30);
    endtask
    // init brings the fractional output up; a live pin change parks it
    task t_init;
        host.xfer(1'b1, `PCS_OFF_INIT, 32'h1);
        wt(7);
        chk(32'(frac), 32'h1);
        pd <= 4'h1;
        wt(3);
        chk(32'(frac), 32'h0);
        host.reload(`PCS_OFF_BANK_D, 32'h21);
        wt(2);
        chk(32'(dsync), 32'h1);
        wt(5);
        chk(32'(frac), 32'h1);
        host.xfer(1'b0, 12'h100, 32'h0);
        chk(32'(host.err_q), 32'h1);
        chk(host.rd_q, 32'h0);
    endtask
    task t_lock;
        lck <= 1'b1;
        wt(2);
        chk(32'(lock_out), 32'h1);
        lck <= 1'b0;
        wt(2);
        chk(32'(lock_out), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_reset();
        t_preset();
        t_reg();
        t_init();
        t_lock();
        host.xfer(1'b1, `PCS_OFF_CTRL, 32'h1F);
        wt(2);
        chk({16'h0, pll_cfg}, 32'h0819);
        rst();
        wt(2);
        chk({16'h0, pll_cfg}, 32'h0414);
        chk(32'(dsync), 32'h1);
        host.xfer(1'b0, `PCS_OFF_PLL, 32'h0);
        chk(host.rd_q, 32'h0);
        summarize();
    end
    // hang guard, far above the roughly 140 cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end
endmodule // pin_register_config_select_test
